// ### pkg/ebx_consts.svh
// How it works
// - window hit drops chip select, starts sequencer
// - narrow mode aliases 64 KB twice
// - wide mode maps 128 KB linearly
// - wide mode: AD carries address then data
// - narrow mode: AD high byte stays address
// - wide transfers split into several external accesses
// - three-bit code divides system clock
// - pins change once per bus clock step
// - one bus clock address setup first
// - latch strobe high for field plus one
// - one latch hold, one turnaround clock
// - after latch hold: float data lines for read, drive write
// - strobe low for field plus one clocks
// - data hold field plus one, then release
// - idle after writes and between reads
// - idle cycles keep all controls inactive
// - width bit selects sixteen or eight bits
// - enable bit turns interface on
// - write hold skip drops hold on writes
// - read hold skip drops hold on reads
// - chip select high during inserted idle
`ifndef EBX_CONSTS_SVH
`define EBX_CONSTS_SVH
`define EBX_AXI_AW 8
`define EBX_OFF_CTRL 8'h00
`define EBX_OFF_TIME 8'h04
`define EBX_OFF_CTRL2 8'h08
`define EBX_OFF_STAT 8'h0C
`define EBX_RST_VAL 32'h0000_0000
`define EBX_CTRL_MASK 32'h0007_0703
`define EBX_TIME_MASK 32'h0F00_F7F8
`define EBX_CTRL2_MASK 32'h0000_0007
`define EBX_BIT_EN 0
`define EBX_BIT_WIDE 1
`define EBX_DIV_MSB 10
`define EBX_DIV_LSB 8
`define EBX_DIV_MAX 3'h5
`define EBX_ALE_MSB 18
`define EBX_ALE_LSB 16
`define EBX_ACC_MSB 7
`define EBX_ACC_LSB 3
`define EBX_AHD_MSB 10
`define EBX_AHD_LSB 8
`define EBX_W2X_MSB 15
`define EBX_W2X_LSB 12
`define EBX_R2R_MSB 27
`define EBX_R2R_LSB 24
`define EBX_BIT_WSKIP 2
`define EBX_BIT_RSKIP 1
`define EBX_WIN_TAG 15'h3000
`define EBX_WIN_LSB 17
`define EBX_FIXED_TICKS 5'h00
`define EBX_RESP_OKAY 2'h0
`define EBX_RESP_SLVERR 2'h2
`endif

// ### pkg/ebx_pkg.sv
package ebx_pkg;
  typedef enum logic [7:0] {
    EBX_IDLE = 8'h01,
    EBX_SETUP = 8'h02,
    EBX_LATCH = 8'h04,
    EBX_LHOLD = 8'h08,
    EBX_TURN = 8'h10,
    EBX_ACCESS = 8'h20,
    EBX_HOLD = 8'h40,
    EBX_GAP = 8'h80
  } ebx_state_t;
  typedef enum logic [1:0] {
    EBX_SZ_BYTE = 2'h0,
    EBX_SZ_HALF = 2'h1,
    EBX_SZ_WORD = 2'h2
  } ebx_size_t;
endpackage

// ### rtl/ebx_top.sv
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "ebx_consts.svh"
module ebx_top
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sys_req,
  input wire logic [31:0] sys_addr,
  input wire logic sys_write,
  input wire logic [1:0] sys_size,
  input wire logic [31:0] sys_wdata,
  output logic sys_ready,
  output logic sys_done,
  output logic sys_err,
  output logic [31:0] sys_rdata,
  output logic ext_chip_select_low,
  output logic addr_latch_strobe,
  output logic read_strobe_low,
  output logic write_strobe_low,
  output logic [15:0] ad_out,
  output logic [15:0] ad_oe,
  input wire logic [15:0] ad_in
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [31:0] ctrl_reg;
  logic [31:0] time_reg;
  logic [31:0] ctrl2_reg;
  logic aw_have_reg;
  logic w_have_reg;
  logic [7:0] awaddr_hold_reg;
  logic [31:0] wdata_hold_reg;
  logic [3:0] wstrb_hold_reg;
  logic wr_fire;
  logic wr_hit;

  logic interface_enable;
  logic wide_bus_select;
  logic [2:0] bus_clock_divider;
  logic [2:0] latch_pulse_length;
  logic [4:0] access_time_length;
  logic [2:0] hold_time_length;
  logic [3:0] after_write_idle;
  logic [3:0] read_to_read_idle;
  logic write_hold_skip;
  logic read_hold_skip;

  assign interface_enable = ctrl_reg[`EBX_BIT_EN];
  assign wide_bus_select = ctrl_reg[`EBX_BIT_WIDE];
  assign bus_clock_divider = ctrl_reg[`EBX_DIV_MSB:`EBX_DIV_LSB];
  assign latch_pulse_length = ctrl_reg[`EBX_ALE_MSB:`EBX_ALE_LSB];
  assign access_time_length = time_reg[`EBX_ACC_MSB:`EBX_ACC_LSB];
  assign hold_time_length = time_reg[`EBX_AHD_MSB:`EBX_AHD_LSB];
  assign after_write_idle = time_reg[`EBX_W2X_MSB:`EBX_W2X_LSB];
  assign read_to_read_idle = time_reg[`EBX_R2R_MSB:`EBX_R2R_LSB];
  assign write_hold_skip = ctrl2_reg[`EBX_BIT_WSKIP];
  assign read_hold_skip = ctrl2_reg[`EBX_BIT_RSKIP];

  function automatic logic [31:0] ebx_merge(input logic [31:0] old_v,
    input logic [31:0] new_v, input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res & mask;
  endfunction

  assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign wr_hit = (awaddr_hold_reg == `EBX_OFF_CTRL) || (awaddr_hold_reg == `EBX_OFF_TIME) ||
    (awaddr_hold_reg == `EBX_OFF_CTRL2) || (awaddr_hold_reg == `EBX_OFF_STAT);

  // ---------------------------------------------------------------
  // axi write channel
  // ---------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `EBX_RESP_OKAY;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_hold_reg <= 8'h00;
      wdata_hold_reg <= 32'h0000_0000;
      wstrb_hold_reg <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_reg <= 1'b1;
        awaddr_hold_reg <= {s_axi_awaddr[7:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_reg <= 1'b1;
        wdata_hold_reg <= s_axi_wdata;
        wstrb_hold_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `EBX_RESP_OKAY : `EBX_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg <= `EBX_RST_VAL;
      time_reg <= `EBX_RST_VAL;
      ctrl2_reg <= `EBX_RST_VAL;
    end
    else if (wr_fire)
    begin
      case (awaddr_hold_reg)
        `EBX_OFF_CTRL: ctrl_reg <= ebx_merge(ctrl_reg, wdata_hold_reg, wstrb_hold_reg,
          `EBX_CTRL_MASK);
        `EBX_OFF_TIME: time_reg <= ebx_merge(time_reg, wdata_hold_reg, wstrb_hold_reg,
          `EBX_TIME_MASK);
        `EBX_OFF_CTRL2: ctrl2_reg <= ebx_merge(ctrl2_reg, wdata_hold_reg, wstrb_hold_reg,
          `EBX_CTRL2_MASK);
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // sequencer state
  // ---------------------------------------------------------------
  ebx_pkg::ebx_state_t state_reg;
  ebx_pkg::ebx_state_t state_next;
  logic [4:0] tcnt_reg;
  logic [4:0] tcnt_next;
  logic pend_reg;
  logic more_reg;
  logic prev_rd_reg;
  logic wr_op_reg;
  logic [31:0] addr_reg;
  logic [31:0] wdata_reg;
  logic [1:0] beat_reg;
  logic [1:0] last_beat_reg;
  logic [1:0] beat_use;
  logic beat_end;
  logic cap;
  logic take;
  logic hit;

  // ---------------------------------------------------------------
  // axi read channel
  // ---------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `EBX_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `EBX_RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        `EBX_OFF_CTRL: s_axi_rdata <= ctrl_reg;
        `EBX_OFF_TIME: s_axi_rdata <= time_reg;
        `EBX_OFF_CTRL2: s_axi_rdata <= ctrl2_reg;
        `EBX_OFF_STAT: s_axi_rdata <= {22'h00_0000, more_reg, pend_reg, state_reg};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `EBX_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // bus clock step divider
  // ---------------------------------------------------------------
  logic [2:0] div_sel;
  logic [5:0] period;
  logic [4:0] dcnt_reg;
  logic tick;

  assign div_sel = (bus_clock_divider > `EBX_DIV_MAX) ? 3'h0 : bus_clock_divider;
  assign period = 6'h01 << div_sel;
  // one step per bus period: every edge at divide by one, last edge of the period otherwise
  assign tick = (dcnt_reg == 5'(period - 6'h01));

  always_ff @(posedge aclk)
  begin
    if (!aresetn || tick)
    begin
      dcnt_reg <= 5'h00;
    end
    else
    begin
      dcnt_reg <= dcnt_reg + 5'h01;
    end
  end

  // ---------------------------------------------------------------
  // synchroniser for the AD inputs
  // ---------------------------------------------------------------
  logic [15:0] ad_meta_reg;
  logic [15:0] ad_sync_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ad_meta_reg <= 16'h0000;
      ad_sync_reg <= 16'h0000;
    end
    else
    begin
      ad_meta_reg <= ad_in;
      ad_sync_reg <= ad_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // system request port
  // ---------------------------------------------------------------
  assign hit = (sys_addr[31:`EBX_WIN_LSB] == `EBX_WIN_TAG);
  assign take = sys_req && sys_ready;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sys_ready <= 1'b1;
      sys_done <= 1'b0;
      sys_err <= 1'b0;
      pend_reg <= 1'b0;
      wr_op_reg <= 1'b0;
      addr_reg <= 32'h0000_0000;
      wdata_reg <= 32'h0000_0000;
      last_beat_reg <= 2'h0;
    end
    else
    begin
      sys_done <= 1'b0;
      if (take)
      begin
        sys_ready <= 1'b0;
        addr_reg <= sys_addr;
        wdata_reg <= sys_wdata;
        wr_op_reg <= sys_write;
        case (sys_size)
          ebx_pkg::EBX_SZ_HALF: last_beat_reg <= wide_bus_select ? 2'h0 : 2'h1;
          ebx_pkg::EBX_SZ_WORD: last_beat_reg <= wide_bus_select ? 2'h1 : 2'h3;
          default: last_beat_reg <= 2'h0;
        endcase
        if (hit && interface_enable)
        begin
          pend_reg <= 1'b1;
        end
        else
        begin
          sys_done <= 1'b1;
          sys_err <= 1'b1;
        end
      end
      else if (!pend_reg && !more_reg && state_reg == ebx_pkg::EBX_IDLE && !sys_done)
      begin
        sys_ready <= 1'b1;
      end
      if (tick && state_reg == ebx_pkg::EBX_IDLE && pend_reg)
      begin
        pend_reg <= 1'b0;
      end
      if (!interface_enable && (more_reg || pend_reg) && !take)
      begin
        pend_reg <= 1'b0;
        sys_done <= 1'b1;
        sys_err <= 1'b1;
      end
      else if (tick && beat_end && beat_reg == last_beat_reg)
      begin
        sys_done <= 1'b1;
        sys_err <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // access sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    beat_end = 1'b0;
    cap = 1'b0;
    tcnt_next = (tcnt_reg == 5'h00) ? 5'h00 : tcnt_reg - 5'h01;
    if (tcnt_reg == 5'h00)
    begin
      case (state_reg)
        ebx_pkg::EBX_IDLE:
        begin
          if (pend_reg && prev_rd_reg && !wr_op_reg && read_to_read_idle != 4'h0)
          begin
            state_next = ebx_pkg::EBX_GAP;
            tcnt_next = {1'b0, read_to_read_idle - 4'h1};
          end
          else if (pend_reg)
          begin
            state_next = ebx_pkg::EBX_SETUP;
            tcnt_next = `EBX_FIXED_TICKS;
          end
        end
        ebx_pkg::EBX_SETUP:
        begin
          state_next = ebx_pkg::EBX_LATCH;
          tcnt_next = {2'b00, latch_pulse_length};
        end
        ebx_pkg::EBX_LATCH:
        begin
          state_next = ebx_pkg::EBX_LHOLD;
          tcnt_next = `EBX_FIXED_TICKS;
        end
        ebx_pkg::EBX_LHOLD:
        begin
          state_next = ebx_pkg::EBX_TURN;
          tcnt_next = `EBX_FIXED_TICKS;
        end
        ebx_pkg::EBX_TURN:
        begin
          state_next = ebx_pkg::EBX_ACCESS;
          tcnt_next = access_time_length;
        end
        ebx_pkg::EBX_ACCESS:
        begin
          cap = !wr_op_reg;
          if (wr_op_reg ? write_hold_skip : read_hold_skip)
          begin
            beat_end = 1'b1;
          end
          else
          begin
            state_next = ebx_pkg::EBX_HOLD;
            tcnt_next = {2'b00, hold_time_length};
          end
        end
        ebx_pkg::EBX_HOLD: beat_end = 1'b1;
        ebx_pkg::EBX_GAP: state_next = more_reg ? ebx_pkg::EBX_SETUP : ebx_pkg::EBX_IDLE;
        default: state_next = ebx_pkg::EBX_IDLE;
      endcase
      if (beat_end)
      begin
        if (wr_op_reg && after_write_idle != 4'h0)
        begin
          state_next = ebx_pkg::EBX_GAP;
          tcnt_next = {1'b0, after_write_idle - 4'h1};
        end
        else if (beat_reg == last_beat_reg)
        begin
          state_next = ebx_pkg::EBX_IDLE;
        end
        else if (!wr_op_reg && read_to_read_idle != 4'h0)
        begin
          state_next = ebx_pkg::EBX_GAP;
          tcnt_next = {1'b0, read_to_read_idle - 4'h1};
        end
        else
        begin
          state_next = ebx_pkg::EBX_SETUP;
        end
      end
    end
  end

  assign beat_use = beat_end ? beat_reg + 2'h1 : beat_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !interface_enable)
    begin
      state_reg <= ebx_pkg::EBX_IDLE;
      tcnt_reg <= 5'h00;
      more_reg <= 1'b0;
      beat_reg <= 2'h0;
      prev_rd_reg <= 1'b0;
    end
    else
    begin
      // a refused request never starts the sequencer
      if (take && hit)
      begin
        more_reg <= 1'b1;
        beat_reg <= 2'h0;
      end
      if (tick)
      begin
        state_reg <= state_next;
        tcnt_reg <= tcnt_next;
        if (beat_end)
        begin
          beat_reg <= beat_reg + 2'h1;
          more_reg <= (beat_reg != last_beat_reg);
          prev_rd_reg <= !wr_op_reg;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // read data assembly
  // ---------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sys_rdata <= 32'h0000_0000;
    end
    else if (take)
    begin
      sys_rdata <= 32'h0000_0000;
    end
    else if (tick && cap && wide_bus_select)
    begin
      sys_rdata[{beat_reg[0], 4'h0} +: 16] <= ad_sync_reg;
    end
    else if (tick && cap)
    begin
      sys_rdata[{beat_reg, 3'h0} +: 8] <= ad_sync_reg[7:0];
    end
  end

  // ---------------------------------------------------------------
  // external pins
  // ---------------------------------------------------------------
  logic active_next;
  logic addr_phase_next;
  logic [15:0] ext_addr;
  logic [7:0] wbyte;
  logic [15:0] whalf;

  assign active_next = (state_next != ebx_pkg::EBX_IDLE) && (state_next != ebx_pkg::EBX_GAP);
  assign addr_phase_next = (state_next == ebx_pkg::EBX_SETUP) ||
    (state_next == ebx_pkg::EBX_LATCH) || (state_next == ebx_pkg::EBX_LHOLD);
  // narrow mode drops window bit 16 so both halves alias
  assign ext_addr = wide_bus_select ? addr_reg[16:1] + {14'h0000, beat_use}
    : addr_reg[15:0] + {14'h0000, beat_use};
  assign wbyte = wdata_reg[{beat_use, 3'h0} +: 8];
  assign whalf = wdata_reg[{beat_use[0], 4'h0} +: 16];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ext_chip_select_low <= 1'b1;
      addr_latch_strobe <= 1'b0;
      read_strobe_low <= 1'b1;
      write_strobe_low <= 1'b1;
      ad_out <= 16'h0000;
      ad_oe <= 16'h0000;
    end
    else if (!interface_enable || (tick && !active_next))
    begin
      ext_chip_select_low <= 1'b1;
      addr_latch_strobe <= 1'b0;
      read_strobe_low <= 1'b1;
      write_strobe_low <= 1'b1;
      ad_oe <= 16'h0000;
    end
    else if (tick)
    begin
      ext_chip_select_low <= 1'b0;
      addr_latch_strobe <= (state_next == ebx_pkg::EBX_LATCH);
      read_strobe_low <= !(state_next == ebx_pkg::EBX_ACCESS && !wr_op_reg);
      write_strobe_low <= !(state_next == ebx_pkg::EBX_ACCESS && wr_op_reg);
      if (addr_phase_next)
      begin
        ad_out <= ext_addr;
        ad_oe <= 16'hFFFF;
      end
      else if (wide_bus_select)
      begin
        ad_out <= wr_op_reg ? whalf : 16'h0000;
        ad_oe <= wr_op_reg ? 16'hFFFF : 16'h0000;
      end
      else
      begin
        ad_out <= {ext_addr[15:8], wr_op_reg ? wbyte : 8'h00};
        ad_oe <= wr_op_reg ? 16'hFFFF : 16'hFF00;
      end
    end
  end

endmodule
`default_nettype wire

// ### tb/ebx_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ebx_top_assertions
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sys_req,
  input wire logic [31:0] sys_addr,
  input wire logic sys_ready,
  input wire logic sys_done,
  input wire logic sys_err,
  input wire logic ext_chip_select_low,
  input wire logic addr_latch_strobe,
  input wire logic read_strobe_low,
  input wire logic write_strobe_low,
  input wire logic [15:0] ad_oe
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  reset_idle_a: assert property (
    $rose(aresetn) |-> ext_chip_select_low && !addr_latch_strobe && ad_oe == 16'h0000)
    else $error("bus active after reset");
  strobe_cs_a: assert property (
    !read_strobe_low || !write_strobe_low |-> !ext_chip_select_low && !addr_latch_strobe)
    else $error("strobe outside chip select");
  read_float_a: assert property (
    !read_strobe_low |-> ad_oe[7:0] == 8'h00 && write_strobe_low)
    else $error("data lines driven during read");
  write_drive_a: assert property (
    !write_strobe_low |-> ad_oe == 16'hFFFF)
    else $error("write data not driven");
  latch_setup_a: assert property (
    $rose(addr_latch_strobe) |-> !$past(ext_chip_select_low) && ad_oe == 16'hFFFF)
    else $error("no address setup before latch");
  latch_turn_a: assert property (
    $fell(addr_latch_strobe) |->
      (read_strobe_low && write_strobe_low && !ext_chip_select_low) [*2])
    else $error("strobe too soon after latch");
  take_stall_a: assert property (
    sys_req && sys_ready |=> !sys_ready)
    else $error("ready stayed high after take");
  miss_err_a: assert property (
    sys_req && sys_ready && sys_addr[31:17] != 15'h3000 |-> ##[1:2] (sys_done && sys_err))
    else $error("miss not refused");
endmodule

bind ebx_top ebx_top_assertions ebx_top_assertions_inst
(
  .aclk, .aresetn, .sys_req, .sys_addr, .sys_ready, .sys_done, .sys_err,
  .ext_chip_select_low, .addr_latch_strobe, .read_strobe_low, .write_strobe_low, .ad_oe
);
`default_nettype wire

// ### tb/ebx_ext_mem.sv
`timescale 1ns/1ps
`default_nettype none
module ebx_ext_mem
(
  input wire logic aclk,
  input wire logic narrow,
  input wire logic ext_chip_select_low,
  input wire logic addr_latch_strobe,
  input wire logic read_strobe_low,
  input wire logic write_strobe_low,
  input wire logic [15:0] ad_out,
  input wire logic [15:0] ad_oe,
  output logic [15:0] ad_in
);
  logic [15:0] mem [0:65535];
  logic [15:0] lat;
  logic [15:0] prev = 16'h0000;
  logic [15:0] addr;
  logic drive;
  // transparent address latch on the strobe
  always_latch
  begin
    if (addr_latch_strobe)
      lat <= ad_out;
  end
  // narrow parts take the high address byte straight off the pins
  assign addr = narrow ? {ad_out[15:8] & ad_oe[15:8], lat[7:0]} : lat;
  assign drive = !ext_chip_select_low && !read_strobe_low;
  // undriven lines show the inverse of their last level
  assign ad_in = (ad_oe & ad_out) | (~ad_oe & (drive ? mem[addr] : ~prev));
  always @(posedge aclk)
  begin
    prev <= ad_in;
    if (!ext_chip_select_low && !write_strobe_low)
      mem[addr] <= ad_in;
  end
endmodule
`default_nettype wire

// ### tb/ebx_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ebx_top_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, sys_addr = 32'h0, sys_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sys_req = 1'b0, sys_write = 1'b0;
  logic [1:0] sys_size = 2'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, sys_rdata;
  logic sys_ready, sys_done, sys_err;
  logic ext_chip_select_low, addr_latch_strobe, read_strobe_low, write_strobe_low;
  logic [15:0] ad_out, ad_oe, ad_in;
  logic narrow_mode = 1'b0;
  logic [31:0] rmask [3] = '{32'h0007_0703, 32'h0F00_F7F8, 32'h0000_0007};
  int mismatches = 0;
  int check_count = 0;
  int ale_c = 0, rd_c = 0, csl_c = 0, csh_c = 0, ale_n = 0, n0 = 0, t = 0;
  int ale_len = 0, rd_len = 0, csl_len = 0, csh_max = 0;

  ebx_top ebx_top_inst
  (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sys_req, .sys_addr, .sys_write,
    .sys_size, .sys_wdata, .sys_ready, .sys_done, .sys_err, .sys_rdata,
    .ext_chip_select_low, .addr_latch_strobe, .read_strobe_low, .write_strobe_low,
    .ad_out, .ad_oe, .ad_in
  );
  ebx_ext_mem ebx_ext_mem_inst
  (
    .aclk, .narrow(narrow_mode), .ext_chip_select_low, .addr_latch_strobe,
    .read_strobe_low, .write_strobe_low, .ad_out, .ad_oe, .ad_in
  );

  always #2 aclk = ~aclk;

  // ----
  // pulse length monitor
  // ----
  always @(posedge aclk)
  begin
    ale_c <= addr_latch_strobe ? ale_c + 1 : 0;
    rd_c <= read_strobe_low ? 0 : rd_c + 1;
    csl_c <= ext_chip_select_low ? 0 : csl_c + 1;
    csh_c <= (ext_chip_select_low && !sys_ready) ? csh_c + 1 : 0;
    if (!addr_latch_strobe && ale_c != 0)
    begin
      ale_len <= ale_c;
      ale_n <= ale_n + 1;
    end
    if (read_strobe_low && rd_c != 0)
      rd_len <= rd_c;
    if (ext_chip_select_low && csl_c != 0)
      csl_len <= csl_c;
    if (!ext_chip_select_low && csh_c > csh_max)
      csh_max <= csh_c;
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    chk("bresp", 32'(s_axi_bresp), 32'(r));
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    chk("rdata", s_axi_rdata, e);
    chk("rresp", 32'(s_axi_rresp), 32'(r));
    s_axi_rready <= 1'b0;
  endtask

  // one system transfer; d is write data or expected read data
  task automatic xfer(input logic [31:0] a, input logic w, input logic [1:0] sz,
    input logic [31:0] d, input logic e, input int ales);
    n0 = ale_n;
    @(posedge aclk);
    sys_addr <= a;
    sys_write <= w;
    sys_size <= sz;
    sys_wdata <= d;
    sys_req <= 1'b1;
    do
      @(posedge aclk);
    while (!sys_ready);
    sys_req <= 1'b0;
    do
      @(posedge aclk);
    while (!sys_done);
    chk("sys_err", 32'(sys_err), 32'(e));
    @(posedge aclk);
    chk("latch_pulses", 32'(ale_n - n0), 32'(ales));
    if (!w && !e)
      chk("sys_rdata", sys_rdata, d);
  endtask

  initial
  begin
    repeat (40000) @(posedge aclk);
    mismatches++;
    complete_run();
  end

  // ----
  // main sequence
  // ----
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      axr(8'(i * 4), 32'h0, 2'h0);
      axw(8'(i * 4), 32'hFFFF_FFFF, 2'h0);
      axr(8'(i * 4), rmask[i], 2'h0);
    end
    axw(8'h10, 32'h1, 2'h2);
    axr(8'h10, 32'h0, 2'h2);
    axw(8'h0C, 32'hFFFF_FFFF, 2'h0);
    axr(8'h0C, 32'h0000_0001, 2'h0);
    axw(8'h00, 32'h0, 2'h0);
    xfer(32'h6000_0000, 1'b0, 2'h2, 32'h0, 1'b1, 0);
    axw(8'h00, 32'h3, 2'h0);
    xfer(32'h6002_0000, 1'b0, 2'h2, 32'h0, 1'b1, 0);
    xfer(32'h5FFF_FFFC, 1'b1, 2'h2, 32'h0, 1'b1, 0);
    axw(8'h04, 32'h0000_5018, 2'h0);
    csh_max = 0;
    xfer(32'h6001_0008, 1'b1, 2'h2, 32'hA5C3_1E2D, 1'b0, 2);
    chk("write_gap", 32'(csh_max), 32'h5);
    axw(8'h04, 32'h0300_0018, 2'h0);
    csh_max = 0;
    xfer(32'h6001_0008, 1'b0, 2'h2, 32'hA5C3_1E2D, 1'b0, 2);
    chk("read_gap", 32'(csh_max), 32'h3);
    xfer(32'h6000_0008, 1'b1, 2'h1, 32'h0000_7E81, 1'b0, 1);
    xfer(32'h6001_0008, 1'b0, 2'h2, 32'hA5C3_1E2D, 1'b0, 2);
    narrow_mode = 1'b1;
    axw(8'h00, 32'h1, 2'h0);
    xfer(32'h6000_3421, 1'b1, 2'h0, 32'h5A, 1'b0, 1);
    xfer(32'h6001_3421, 1'b0, 2'h0, 32'h5A, 1'b0, 1);
    xfer(32'h6000_3440, 1'b1, 2'h2, 32'h1122_3344, 1'b0, 4);
    xfer(32'h6001_3440, 1'b0, 2'h2, 32'h1122_3344, 1'b0, 4);
    xfer(32'h6001_3442, 1'b0, 2'h1, 32'h1122, 1'b0, 2);
    narrow_mode = 1'b0;
    for (int d = 0; d < 8; d++)
    begin
      t = (d < 6) ? (1 << d) : 1;
      axw(8'h00, 32'h0002_0003 | (32'(d) << 8), 2'h0);
      axw(8'h04, 32'h0000_0118, 2'h0);
      axw(8'h08, 32'(d & 3) << 1, 2'h0);
      xfer(32'h6000_0100, 1'b1, 2'h1, 32'hC3A0 + 32'(d), 1'b0, 1);
      chk("cs_low_write", 32'(csl_len), 32'((d & 2) ? 10 * t : 12 * t));
      xfer(32'h6000_0100, 1'b0, 2'h1, 32'hC3A0 + 32'(d), 1'b0, 1);
      chk("cs_low_read", 32'(csl_len), 32'((d & 1) ? 10 * t : 12 * t));
      chk("strobe_low", 32'(rd_len), 32'(4 * t));
      chk("latch_high", 32'(ale_len), 32'(3 * t));
    end
    complete_run();
  end
endmodule
`default_nettype wire
